// ---- include/dlldk_pkg.sv ----
package dlldk_pkg;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_MHZ        = 50;
   localparam int CLK_PERIOD_NS  = 20;
   localparam int MIN_REF_MHZ    = 5;
   // longest reference period in clock cycles, rounded down
   localparam int MAX_REF_CYCLES = CLK_MHZ / MIN_REF_MHZ;
   localparam int PW             = 8;
   // halving doubles the longest period seen after the input stage
   localparam logic [PW-1:0] MAX_PERIOD = PW'(2 * MAX_REF_CYCLES);
   // the doubled outputs need at least four cycles per period
   localparam logic [PW-1:0] MIN_PERIOD = 8'h04;
   localparam int LOCK_CW              = 3;
   localparam logic [LOCK_CW-1:0] LOCK_MATCHES = 3'h4;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_HINT     = 8'h04;
   localparam logic [7:0] OFS_STATUS   = 8'h08;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

   localparam int CTRL_W          = 10;
   localparam int HINT_W          = 16;
   localparam int STAT_LOCK_BIT   = 0;
   localparam int STAT_PERIOD_LSB = 8;
   localparam int STAT_DELAY_LSB  = 16;
   localparam int IRQ_W           = 3;
   localparam int IRQ_GAINED_BIT  = 0;
   localparam int IRQ_LOST_BIT    = 1;
   localparam int IRQ_SLOW_BIT    = 2;

   // divide ratio held as twice the ratio: 3 (1.5) up to 32 (16)
   localparam logic [5:0] RATIO2_MIN     = 6'h03;
   localparam logic [5:0] RATIO2_MAX     = 6'h20;
   localparam logic [5:0] RATIO2_DEFAULT = 6'h04;

   typedef enum logic [1:0] {
      FB_NONE,
      FB_SINGLE,
      FB_DOUBLE
   } dlldk_fb_t;

   typedef enum logic [2:0] {
      REG_CTRL,
      REG_HINT,
      REG_STATUS,
      REG_IRQ_STAT,
      REG_IRQ_MASK,
      REG_NONE
   } dlldk_reg_t;

   // bit 0 enable, bit 1 halve, bits 3:2 feedback, bits 9:4 ratio
   typedef struct packed {
      logic [5:0] ratio2;
      dlldk_fb_t  fb_sel;
      logic       halve;
      logic       enable;
   } dlldk_ctrl_t;

   localparam dlldk_ctrl_t CTRL_RESET = '{ratio2: RATIO2_DEFAULT, fb_sel: FB_SINGLE,
                                          halve: 1'b0, enable: 1'b0};
   localparam logic [HINT_W-1:0] HINT_RESET = 16'h0000;
   localparam logic [IRQ_W-1:0]  MASK_RESET = 3'h0;

   typedef struct packed {
      logic div;
      logic dbl_inv;
      logic dbl;
      logic q270;
      logic q180;
      logic q90;
      logic q0;
   } dlldk_clks_t;

endpackage : dlldk_pkg

// ---- hw/dlldk_ref_meter.sv ----
module dlldk_ref_meter (
   input  wire logic                       ref_clk,
   input  wire logic                       rst,
   input  wire logic                       enable,
   input  wire logic                       halve,
   input  wire logic                       level,
   output logic                            rise,
   output logic [dlldk_pkg::PW-1:0]        period,
   output logic                            period_ok,
   output logic                            too_slow
);

   logic                     prev_reg;
   logic                     half_reg;
   logic [dlldk_pkg::PW-1:0] count_reg;
   logic [dlldk_pkg::PW-1:0] period_reg;
   logic                     ok_reg;
   logic                     raw_rise;
   logic                     saturating;

   // ****************************************
   // input stage
   // ****************************************
   assign raw_rise   = level & ~prev_reg;
   assign rise       = enable & raw_rise & (~halve | half_reg);
   assign saturating = (count_reg == dlldk_pkg::MAX_PERIOD - 8'h01) & ~rise;
   assign too_slow   = enable & saturating;
   assign period     = period_reg;
   assign period_ok  = ok_reg;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         prev_reg <= 1'b0;
         half_reg <= 1'b0;
      end else begin
         prev_reg <= level;
         if (!enable) begin
            half_reg <= 1'b0;
         end else if (raw_rise) begin
            half_reg <= ~half_reg;
         end
      end
   end

   // ****************************************
   // period measurement
   // ****************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         count_reg  <= dlldk_pkg::MAX_PERIOD;
         period_reg <= 8'h00;
         ok_reg     <= 1'b0;
      end else if (!enable) begin
         count_reg  <= dlldk_pkg::MAX_PERIOD;
         ok_reg     <= 1'b0;
      end else if (rise) begin
         count_reg  <= 8'h01;
         period_reg <= count_reg;
         // two equal periods in a row before the loop trusts them
         ok_reg     <= (count_reg != dlldk_pkg::MAX_PERIOD) &&
                       (count_reg == period_reg) &&
                       (count_reg >= dlldk_pkg::MIN_PERIOD);
      end else if (count_reg != dlldk_pkg::MAX_PERIOD) begin
         count_reg  <= count_reg + 8'h01;
         if (saturating) begin
            ok_reg  <= 1'b0;
         end
      end
   end

endmodule : dlldk_ref_meter

// ---- hw/dlldk_top.sv ----
module dlldk_top (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        reference_clock_in,
   input  wire logic        feedback_clock_in,
   output logic             aligned_clock_out,
   output logic             quarter_phase_clock_out,
   output logic             half_phase_clock_out,
   output logic             three_quarter_phase_clock_out,
   output logic             doubled_clock_out,
   output logic             doubled_inverted_clock_out,
   output logic             divided_clock_out,
   output logic             lock_indicator,
   output logic             irq
);

   typedef enum {STEP_NONE, STEP_ADVANCE, STEP_RETARD} dlldk_step_t;

   // ****************************************
   // helpers
   // ****************************************
   function automatic dlldk_pkg::dlldk_reg_t reg_decode(input logic [7:0] addr);
      if (addr == dlldk_pkg::OFS_CTRL) begin
         return dlldk_pkg::REG_CTRL;
      end else if (addr == dlldk_pkg::OFS_HINT) begin
         return dlldk_pkg::REG_HINT;
      end else if (addr == dlldk_pkg::OFS_STATUS) begin
         return dlldk_pkg::REG_STATUS;
      end else if (addr == dlldk_pkg::OFS_IRQ_STAT) begin
         return dlldk_pkg::REG_IRQ_STAT;
      end else if (addr == dlldk_pkg::OFS_IRQ_MASK) begin
         return dlldk_pkg::REG_IRQ_MASK;
      end else begin
         return dlldk_pkg::REG_NONE;
      end
   endfunction : reg_decode

   function automatic logic [dlldk_pkg::PW-1:0] wrap_add(
      input logic [dlldk_pkg::PW-1:0] value,
      input logic [dlldk_pkg::PW-1:0] step,
      input logic [dlldk_pkg::PW-1:0] per);
      logic [dlldk_pkg::PW:0] sum;
      sum = {1'b0, value} + {1'b0, step};
      if (sum >= {1'b0, per}) begin
         sum = sum - {1'b0, per};
      end
      return sum[dlldk_pkg::PW-1:0];
   endfunction : wrap_add

   function automatic dlldk_pkg::dlldk_ctrl_t ctrl_clean(input logic [31:0] data);
      dlldk_pkg::dlldk_ctrl_t c;
      c = dlldk_pkg::dlldk_ctrl_t'(data[dlldk_pkg::CTRL_W-1:0]);
      // out-of-range ratios fall back to the default rather than stall the divider
      if (c.ratio2 < dlldk_pkg::RATIO2_MIN || c.ratio2 > dlldk_pkg::RATIO2_MAX) begin
         c.ratio2 = dlldk_pkg::RATIO2_DEFAULT;
      end
      if (data[3:2] == 2'b11) begin
         c.fb_sel = dlldk_pkg::FB_SINGLE;
      end
      return c;
   endfunction : ctrl_clean

   // ****************************************
   // declarations
   // ****************************************
   dlldk_pkg::dlldk_ctrl_t        ctrl_reg;
   logic [dlldk_pkg::HINT_W-1:0]  hint_reg;
   logic [dlldk_pkg::IRQ_W-1:0]   stat_reg;
   logic [dlldk_pkg::IRQ_W-1:0]   mask_reg;
   logic [31:0]                   prdata_reg;
   logic                          pslverr_reg;
   dlldk_pkg::dlldk_reg_t         sel;
   logic                          apb_setup;
   logic                          apb_write;
   logic                          ctrl_wr;

   logic                          ref_rise;
   logic [dlldk_pkg::PW-1:0]      meas_period;
   logic                          period_ok;
   logic                          too_slow;
   logic [dlldk_pkg::HINT_W-1:0]  hint_cycles;
   logic [dlldk_pkg::PW-1:0]      per;
   logic                          running;

   logic [dlldk_pkg::PW-1:0]      ph_reg;
   logic [dlldk_pkg::PW-1:0]      delay_reg;
   logic [dlldk_pkg::PW-1:0]      lag_reg;
   logic [dlldk_pkg::PW-1:0]      lag_now;
   logic [dlldk_pkg::PW-1:0]      thresh;
   logic                          armed_reg;
   logic                          fb_prev_reg;
   logic                          fb_eval;
   dlldk_step_t                   step;

   logic [dlldk_pkg::LOCK_CW-1:0] match_reg;
   logic                          locked_reg;
   logic                          lock_next;
   logic                          gained;
   logic                          lost;
   logic [dlldk_pkg::IRQ_W-1:0]   events;

   dlldk_pkg::dlldk_clks_t        clks_reg;
   logic [dlldk_pkg::PW-1:0]      hp;
   logic [dlldk_pkg::PW-1:0]      qp;
   logic [dlldk_pkg::PW-1:0]      tq;
   logic [dlldk_pkg::PW-1:0]      ph2;
   logic [13:0]                   div_half;
   logic [13:0]                   div_cnt_reg;
   logic                          div_sync_reg;

   // ****************************************
   // apb slave
   // ****************************************
   assign sel       = reg_decode(paddr);
   assign apb_setup = psel & ~penable;
   assign apb_write = psel & penable & pwrite;
   assign ctrl_wr   = apb_write & (sel == dlldk_pkg::REG_CTRL);
   // read data is captured in the setup cycle, so no wait state is needed
   assign pready    = 1'b1;
   assign prdata    = prdata_reg;
   assign pslverr   = pslverr_reg & psel & penable;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else if (apb_setup) begin
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= (sel == dlldk_pkg::REG_NONE);
         if (sel == dlldk_pkg::REG_CTRL) begin
            prdata_reg[dlldk_pkg::CTRL_W-1:0] <= ctrl_reg;
         end else if (sel == dlldk_pkg::REG_HINT) begin
            prdata_reg[dlldk_pkg::HINT_W-1:0] <= hint_reg;
         end else if (sel == dlldk_pkg::REG_STATUS) begin
            prdata_reg[dlldk_pkg::STAT_LOCK_BIT] <= locked_reg;
            prdata_reg[dlldk_pkg::STAT_PERIOD_LSB +: dlldk_pkg::PW] <= meas_period;
            prdata_reg[dlldk_pkg::STAT_DELAY_LSB +: dlldk_pkg::PW] <= delay_reg;
         end else if (sel == dlldk_pkg::REG_IRQ_STAT) begin
            prdata_reg[dlldk_pkg::IRQ_W-1:0] <= stat_reg;
         end else if (sel == dlldk_pkg::REG_IRQ_MASK) begin
            prdata_reg[dlldk_pkg::IRQ_W-1:0] <= mask_reg;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= dlldk_pkg::CTRL_RESET;
         hint_reg <= dlldk_pkg::HINT_RESET;
         mask_reg <= dlldk_pkg::MASK_RESET;
      end else if (apb_write) begin
         if (sel == dlldk_pkg::REG_CTRL) begin
            ctrl_reg <= ctrl_clean(pwdata);
         end else if (sel == dlldk_pkg::REG_HINT) begin
            hint_reg <= pwdata[dlldk_pkg::HINT_W-1:0];
         end else if (sel == dlldk_pkg::REG_IRQ_MASK) begin
            mask_reg <= pwdata[dlldk_pkg::IRQ_W-1:0];
         end
      end
   end

   // ****************************************
   // interrupts
   // ****************************************
   assign events = {too_slow, lost, gained};
   assign irq    = |(stat_reg & mask_reg);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         stat_reg <= 3'h0;
      end else begin
         // a new event wins over a write-one-to-clear in the same cycle
         if (apb_write && sel == dlldk_pkg::REG_IRQ_STAT) begin
            stat_reg <= (stat_reg & ~pwdata[dlldk_pkg::IRQ_W-1:0]) | events;
         end else begin
            stat_reg <= stat_reg | events;
         end
      end
   end

   // ****************************************
   // reference input stage
   // ****************************************
   dlldk_ref_meter u_meter (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .enable    (ctrl_reg.enable),
      .halve     (ctrl_reg.halve),
      .level     (reference_clock_in),
      .rise      (ref_rise),
      .period    (meas_period),
      .period_ok (period_ok),
      .too_slow  (too_slow)
   );

   // the hint only seeds the output period; lock still waits for a measurement
   assign hint_cycles = ctrl_reg.halve ?
                        16'((hint_reg / 16'(dlldk_pkg::CLK_PERIOD_NS)) << 1) :
                        16'(hint_reg / 16'(dlldk_pkg::CLK_PERIOD_NS));
   always_comb begin
      if (period_ok) begin
         per = meas_period;
      end else if (hint_cycles >= 16'(dlldk_pkg::MIN_PERIOD) &&
                   hint_cycles <= 16'(dlldk_pkg::MAX_PERIOD)) begin
         per = hint_cycles[dlldk_pkg::PW-1:0];
      end else begin
         per = 8'h00;
      end
   end
   assign running = ctrl_reg.enable & (per != 8'h00);

   // ****************************************
   // phase detector
   // ****************************************
   assign lag_now = ref_rise ? 8'h00 : lag_reg;
   assign fb_eval = feedback_clock_in & ~fb_prev_reg & (armed_reg | ref_rise) &
                    running & (ctrl_reg.fb_sel != dlldk_pkg::FB_NONE);
   // a doubled feedback returns twice a period, so the early window halves
   assign thresh  = (ctrl_reg.fb_sel == dlldk_pkg::FB_DOUBLE) ? (per >> 2) : (per >> 1);

   always_comb begin
      step = STEP_NONE;
      if (fb_eval && lag_now != 8'h00) begin
         if (lag_now < thresh) begin
            step = STEP_ADVANCE;
         end else begin
            step = STEP_RETARD;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fb_prev_reg <= 1'b0;
         lag_reg     <= 8'h00;
         armed_reg   <= 1'b0;
      end else begin
         fb_prev_reg <= feedback_clock_in;
         if (ref_rise) begin
            lag_reg   <= 8'h01;
            armed_reg <= ~fb_eval;
         end else begin
            if (lag_reg != dlldk_pkg::MAX_PERIOD) begin
               lag_reg <= lag_reg + 8'h01;
            end
            if (fb_eval) begin
               armed_reg <= 1'b0;
            end
         end
      end
   end

   // ****************************************
   // counter-based delay line
   // ****************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ph_reg    <= 8'h00;
         delay_reg <= 8'h00;
      end else if (!running) begin
         ph_reg    <= 8'h00;
         delay_reg <= 8'h00;
      end else if (ctrl_reg.fb_sel == dlldk_pkg::FB_NONE && ref_rise) begin
         ph_reg    <= 8'h00;
      end else begin
         case (step)
            STEP_ADVANCE: begin
               ph_reg    <= wrap_add(ph_reg, 8'h02, per);
               delay_reg <= wrap_add(delay_reg, per - 8'h01, per);
            end
            STEP_RETARD: begin
               delay_reg <= wrap_add(delay_reg, 8'h01, per);
            end
            default: begin
               ph_reg    <= wrap_add(ph_reg, 8'h01, per);
            end
         endcase
      end
   end

   // ****************************************
   // lock detection
   // ****************************************
   always_comb begin
      lock_next = locked_reg;
      if (!running || !period_ok || ctrl_wr) begin
         lock_next = 1'b0;
      end else if (match_reg == dlldk_pkg::LOCK_MATCHES) begin
         lock_next = 1'b1;
      end
   end
   assign gained = lock_next & ~locked_reg;
   assign lost   = ~lock_next & locked_reg;
   assign lock_indicator = locked_reg;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         match_reg  <= 3'h0;
         locked_reg <= 1'b0;
      end else begin
         locked_reg <= lock_next;
         if (!running || !period_ok || ctrl_wr) begin
            match_reg <= 3'h0;
         end else if (match_reg != dlldk_pkg::LOCK_MATCHES) begin
            if (ctrl_reg.fb_sel == dlldk_pkg::FB_NONE) begin
               if (ref_rise) begin
                  match_reg <= match_reg + 3'h1;
               end
            end else if (fb_eval) begin
               // an aligned edge counts, any miss starts over
               match_reg <= (lag_now == 8'h00) ? match_reg + 3'h1 : 3'h0;
            end
         end
      end
   end

   // ****************************************
   // output stage
   // ****************************************
   assign hp       = per >> 1;
   assign qp       = per >> 2;
   assign tq       = qp + hp;
   assign ph2      = (ph_reg >= hp) ? ph_reg - hp : ph_reg;
   assign div_half = 14'((14'(ctrl_reg.ratio2) * 14'(per)) >> 2);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         clks_reg <= 7'h00;
      end else if (!running) begin
         clks_reg <= 7'h00;
      end else begin
         // every output except div comes from the same phase count; all update on the same edge
         clks_reg.q0      <= ph_reg < hp;
         clks_reg.q90     <= (ph_reg >= qp) && (ph_reg < tq);
         clks_reg.q180    <= ph_reg >= hp;
         clks_reg.q270    <= (ph_reg < qp) || (ph_reg >= tq);
         clks_reg.dbl     <= ph2 < qp;
         clks_reg.dbl_inv <= ph2 >= qp;
         if (div_sync_reg && ph_reg == 8'h00) begin
            clks_reg.div  <= 1'b1;
         end else if (!div_sync_reg && div_cnt_reg >= div_half) begin
            clks_reg.div  <= ~clks_reg.div;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         div_cnt_reg  <= 14'h0001;
         div_sync_reg <= 1'b1;
      end else if (!running || ctrl_wr) begin
         div_cnt_reg  <= 14'h0001;
         div_sync_reg <= 1'b1;
      end else if (div_sync_reg) begin
         if (ph_reg == 8'h00) begin
            div_sync_reg <= 1'b0;
         end
      end else if (div_cnt_reg >= div_half) begin
         div_cnt_reg  <= 14'h0001;
      end else begin
         div_cnt_reg  <= div_cnt_reg + 14'h0001;
      end
   end

   assign aligned_clock_out             = clks_reg.q0;
   assign quarter_phase_clock_out       = clks_reg.q90;
   assign half_phase_clock_out          = clks_reg.q180;
   assign three_quarter_phase_clock_out = clks_reg.q270;
   assign doubled_clock_out             = clks_reg.dbl;
   assign doubled_inverted_clock_out    = clks_reg.dbl_inv;
   assign divided_clock_out             = clks_reg.div;

endmodule : dlldk_top

// ---- tb/dlldk_top_sva.sv ----
// ****************************************
// phase relations and bus checks
// ****************************************
module dlldk_top_sva (
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic [7:0] paddr,
   input wire logic       pready,
   input wire logic       pslverr,
   input wire logic       aligned_clock_out,
   input wire logic       quarter_phase_clock_out,
   input wire logic       half_phase_clock_out,
   input wire logic       three_quarter_phase_clock_out,
   input wire logic       doubled_clock_out,
   input wire logic       doubled_inverted_clock_out,
   input wire logic       lock_indicator
);
   default clocking dck @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   // saturates so a stopped output never wraps back to a small gap
   logic [7:0] gap_reg;
   always_ff @(posedge ref_clk) begin
      gap_reg <= $rose(aligned_clock_out) ? 8'h00 : gap_reg + {7'h00, gap_reg != 8'hFF};
   end
   a_lock_low_start: assert property ($fell(rst) |-> !lock_indicator [*8])
      else $error("lock high right after reset");
   a_lock_live_out: assert property (lock_indicator |-> gap_reg <= 8'h2C)
      else $error("locked without a running aligned output");
   // phase relations except the doubled inverted check only bind while locked: outputs restart when the period changes
   a_dbl_same_phase: assert property (lock_indicator && $rose(aligned_clock_out) |->
                                      $rose(doubled_clock_out))
      else $error("doubled output not rising with aligned output");
   a_dbl_inv_anti: assert property ($rose(doubled_clock_out) |-> !doubled_inverted_clock_out)
      else $error("doubled inverted high at doubled rise");
   a_origin_phases: assert property (lock_indicator && $rose(aligned_clock_out) |->
                                     !quarter_phase_clock_out && !half_phase_clock_out)
      else $error("lagging output high at phase origin");
   a_quarter_lag: assert property (lock_indicator && $rose(quarter_phase_clock_out) |->
                                   aligned_clock_out && !half_phase_clock_out)
      else $error("quarter output rose at wrong phase");
   a_three_q_lag: assert property (lock_indicator && $rose(three_quarter_phase_clock_out)
                                   |-> !aligned_clock_out && half_phase_clock_out)
      else $error("three quarter output rose at wrong phase");
   a_ready_zero_wait: assert property (psel && penable |-> pready)
      else $error("bus access not answered at once");
   a_unmapped_err: assert property (psel && penable && paddr > 8'h10 |-> pslverr)
      else $error("unmapped access without error");
   a_err_in_access: assert property (pslverr |-> psel && penable)
      else $error("error outside access phase");
   c_lock: cover property ($rose(lock_indicator));
   c_dbl_inv: cover property ($rose(doubled_inverted_clock_out));
   c_err: cover property (pslverr);
endmodule : dlldk_top_sva

bind dlldk_top dlldk_top_sva i_sva (.ref_clk, .rst, .psel, .penable, .paddr, .pready, .pslverr,
   .aligned_clock_out, .quarter_phase_clock_out, .half_phase_clock_out,
   .three_quarter_phase_clock_out, .doubled_clock_out, .doubled_inverted_clock_out,
   .lock_indicator);

// ---- tb/dlldk_clk_partner.sv ----
// ****************************************
// reference source and clock distribution
// ****************************************
module dlldk_clk_partner (
   input  wire logic       ref_clk,
   input  wire logic       run,
   input  wire logic [7:0] per,
   input  wire logic [2:0] skew,
   input  wire logic       use_dbl,
   input  wire logic       aligned,
   input  wire logic       doubled,
   output logic            ref_o,
   output logic            fb_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cnt_reg = 8'h00;
   logic [7:0] dist_reg = 8'h00;
   // source stops low between runs; one scenario goes below the slowest rate on purpose
   always @(posedge ref_clk) begin
      cnt_reg <= (!run || cnt_reg >= per - 8'h01) ? 8'h00 : cnt_reg + 8'h01;
      dist_reg <= {dist_reg[6:0], use_dbl ? doubled : aligned};
   end
   assign ref_o = run && (cnt_reg < (per >> 1));
   assign fb_o  = dist_reg[skew];
endmodule : dlldk_clk_partner

// ---- tb/test_dlldk_top.sv ----
module test_dlldk_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, q, p;
   logic        pready, pslverr, perr, reference_clock_in, feedback_clock_in;
   logic        aligned_clock_out, quarter_phase_clock_out, half_phase_clock_out, irq;
   logic        three_quarter_phase_clock_out, doubled_clock_out, lock_indicator;
   logic        doubled_inverted_clock_out, divided_clock_out;
   logic        run = 1'b0;
   logic        use_dbl = 1'b0;
   logic [7:0]  per = 8'h0A;
   int          err_count = 0;
   int          compares = 0;
   wire [2:0]   outs = {divided_clock_out, doubled_clock_out, aligned_clock_out};
   dlldk_top i_dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .reference_clock_in, .feedback_clock_in, .aligned_clock_out,
      .quarter_phase_clock_out, .half_phase_clock_out, .three_quarter_phase_clock_out,
      .doubled_clock_out, .doubled_inverted_clock_out, .divided_clock_out,
      .lock_indicator, .irq);
   dlldk_clk_partner i_far (.ref_clk(ref_clk), .run(run), .per(per), .skew(3'h3),
      .use_dbl(use_dbl), .aligned(aligned_clock_out), .doubled(doubled_clock_out),
      .ref_o(reference_clock_in), .fb_o(feedback_clock_in));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      q = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wait_lock(input logic v);
      for (int k = 0; k < 4000 && lock_indicator !== v; k++) @(posedge ref_clk);
      chk(32'(lock_indicator), 32'(v));
   endtask : wait_lock
   // period of one output in cycles, from one rise to the next
   task automatic per_of(input int i);
      int n;
      logic pv;
      n = 0;
      pv = 1'b1;
      p = 32'h0;
      for (int k = 0; k < 400 && n < 2; k++) begin
         @(posedge ref_clk);
         if (n == 1) p++;
         if (outs[i] === 1'b1 && pv === 1'b0) n++;
         pv = outs[i];
      end
   endtask : per_of
   task automatic t_regs();
      chk(32'(lock_indicator), 32'h0);
      apb(1'b0, 8'h00, 32'h0);
      chk(q, 32'h0000_0044);
      apb(1'b0, 8'h20, 32'h0);
      chk({q[30:0], perr}, 32'h1);
      $display("t_regs done");
   endtask : t_regs
   task automatic t_lock();
      logic rp, fp;
      apb(1'b1, 8'h10, 32'h7);
      apb(1'b1, 8'h04, 32'h00C8);
      run <= 1'b1;
      apb(1'b1, 8'h00, 32'h45);
      wait_lock(1'b1);
      chk(32'(irq), 32'h1);
      apb(1'b0, 8'h08, 32'h0);
      chk({q[15:8], 7'h00, q[23:16] != 8'h00}, {8'h0A, 8'h01});
      per_of(0);
      chk(p, 32'h0A);
      per_of(1);
      chk(p, 32'h05);
      per_of(2);
      chk(p, 32'h14);
      rp = 1'b1;
      fp = 1'b1;
      repeat (40) begin
         @(posedge ref_clk);
         if (feedback_clock_in && !fp) chk(32'(reference_clock_in && !rp), 32'h1);
         rp = reference_clock_in;
         fp = feedback_clock_in;
      end
      apb(1'b1, 8'h0C, 32'h1);
      @(posedge ref_clk);
      chk(32'(irq), 32'h0);
      $display("t_lock done");
   endtask : t_lock
   task automatic t_double();
      use_dbl <= 1'b1;
      per <= 8'h0C;
      apb(1'b1, 8'h00, 32'h39);
      apb(1'b1, 8'h10, 32'h1);
      apb(1'b0, 8'h0C, 32'h0);
      chk({q[31:2], irq, q[1]}, 32'h1);
      wait_lock(1'b1);
      chk(32'(irq), 32'h1);
      per_of(2);
      chk(p, 32'h12);
      $display("t_double done");
   endtask : t_double
   task automatic t_halve();
      use_dbl <= 1'b0;
      per <= 8'h05;
      apb(1'b1, 8'h00, 32'h47);
      wait_lock(1'b0);
      wait_lock(1'b1);
      per_of(0);
      chk(p, 32'h0A);
      per <= 8'h1E;
      wait_lock(1'b0);
      apb(1'b0, 8'h0C, 32'h0);
      chk(32'(q[2]), 32'h1);
      $display("t_halve done");
   endtask : t_halve
   task automatic print_verdict();
      $display("mismatches %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : print_verdict
   initial begin
      forever #10 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      t_regs();
      t_lock();
      t_double();
      t_halve();
      print_verdict();
   end
   // each lock wait is bounded at 4000 cycles, so this is well past a healthy run
   initial begin
      repeat (60000) @(posedge ref_clk);
      err_count++;
      print_verdict();
   end
endmodule : test_dlldk_top
